//--- hdl/pvc_regs.sv
// Vendor control registers: PLL save, slow oscillator, symbol errors, strap override.
// Assumes the management deserialiser delivers single-cycle register requests in core_clk.
`include "pvc_defs.svh"
module pvc_regs
  import pvc_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire pvc_req_s req,
  output logic [15:0] rdata,
  input wire logic [15:0] power_ctrl,
  input wire logic symbol_error_frame,
  input wire logic wake_event_strap,
  input wire logic broadcast_strap,
  input wire logic [4:0] phy_addr,
  input wire logic [4:0] mgmt_phy_addr,
  output logic phy_selected,
  output pvc_ctrl_s ctrl
);
  logic [15:0] pll_r, pll_nxt;
  logic [15:0] afe_r, afe_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] ovr_r, ovr_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic wsync1_r, wsync2_r, bsync1_r, bsync2_r;
  logic bcast_strap_r, bcast_strap_nxt;
  pvc_strap_e strap_r, strap_nxt;
  logic energy_detect_power_down;

  // Straps come from pins, so synchronise before sampling.
  // No reset on purpose: the chain keeps filling while arst_n is low,
  // so the capture on the first edge after release sees the pin level.
  always_ff @(posedge core_clk) begin
    wsync1_r <= wake_event_strap;
    wsync2_r <= wsync1_r;
    bsync1_r <= broadcast_strap;
    bsync2_r <= bsync1_r;
  end

  assign energy_detect_power_down = power_ctrl[`PVC_BIT_ENERGY_DETECT_EN];

  always_comb begin
    pll_nxt = pll_r;
    afe_nxt = afe_r;
    ovr_nxt = ovr_r;
    cnt_nxt = cnt_r;
    strap_nxt = strap_r;
    bcast_strap_nxt = bcast_strap_r;
    rdata_nxt = rdata_r;
    // Strap captured on the first edge after release; synchronisers filled during reset
    case (strap_r)
      PVC_STRAP_WAIT: begin
        strap_nxt = PVC_STRAP_DONE;
        ovr_nxt[`PVC_BIT_WAKE_EN] = wsync2_r;
        bcast_strap_nxt = bsync2_r;
      end
      default: begin
        strap_nxt = PVC_STRAP_DONE;
      end
    endcase
    if (symbol_error_frame && cnt_r != 16'hffff) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
    if (req.rd) begin
      if (req.addr == `PVC_OFS_PLL_CTRL) begin
        rdata_nxt = pll_r;
      end else if (req.addr == `PVC_OFS_AFE_CTRL) begin
        rdata_nxt = afe_r;
      end else if (req.addr == `PVC_OFS_SYMERR) begin
        rdata_nxt = cnt_r;
        // Event in the read cycle is kept, not lost
        cnt_nxt = symbol_error_frame ? 16'h0001 : `PVC_RST_SYMERR;
      end else if (req.addr == `PVC_OFS_STRAP_OVR) begin
        rdata_nxt = ovr_r;
      end else begin
        rdata_nxt = 16'h0000;
      end
    end
    if (req.wr) begin
      if (req.addr == `PVC_OFS_PLL_CTRL) begin
        pll_nxt = req.wdata;
      end else if (req.addr == `PVC_OFS_AFE_CTRL) begin
        afe_nxt = req.wdata;
      end else if (req.addr == `PVC_OFS_STRAP_OVR) begin
        ovr_nxt = req.wdata & `PVC_MASK_STRAP_RW;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pll_r <= `PVC_RST_PLL_CTRL;
      afe_r <= `PVC_RST_AFE_CTRL;
      cnt_r <= `PVC_RST_SYMERR;
      ovr_r <= `PVC_RST_STRAP_OVR;
      rdata_r <= 16'h0000;
      bcast_strap_r <= 1'b0;
      strap_r <= PVC_STRAP_WAIT;
    end else begin
      pll_r <= pll_nxt;
      afe_r <= afe_nxt;
      cnt_r <= cnt_nxt;
      ovr_r <= ovr_nxt;
      rdata_r <= rdata_nxt;
      bcast_strap_r <= bcast_strap_nxt;
      strap_r <= strap_nxt;
    end
  end

  assign rdata = rdata_r;
  // One pattern keeps the whole control word on a single driver
  assign ctrl = '{
    pll_off: pll_r[`PVC_BIT_PLL_OFF] & energy_detect_power_down,
    analog_power_down: afe_r[`PVC_BIT_SLOW_OSC],
    slow_osc_select: afe_r[`PVC_BIT_SLOW_OSC],
    wake_event_output_enable: ovr_r[`PVC_BIT_WAKE_EN],
    // Override set: register bit wins; otherwise sampled strap
    broadcast_address_disable: ovr_r[`PVC_BIT_BCAST_OVR] | bcast_strap_r
  };
  // Address 0 answers as broadcast only when disable is off
  assign phy_selected = (mgmt_phy_addr == phy_addr) ||
                        (mgmt_phy_addr == 5'h00 && !ctrl.broadcast_address_disable);

  // Single-cycle bus steps; the checks below look one edge past them
  sequence pll_write_seq;
    req.wr && req.addr == `PVC_OFS_PLL_CTRL;
  endsequence
  sequence afe_write_seq;
    req.wr && req.addr == `PVC_OFS_AFE_CTRL;
  endsequence
  sequence strap_write_seq;
    req.wr && req.addr == `PVC_OFS_STRAP_OVR;
  endsequence
  sequence count_read_seq;
    req.rd && req.addr == `PVC_OFS_SYMERR;
  endsequence
  sequence count_write_seq;
    req.wr && !req.rd && req.addr == `PVC_OFS_SYMERR;
  endsequence

  AST_PLL_OFF: assert property (@(posedge core_clk) disable iff (!arst_n)
    pll_write_seq ##1 power_ctrl[`PVC_BIT_ENERGY_DETECT_EN] |-> ctrl.pll_off == $past(req.wdata[`PVC_BIT_PLL_OFF]))
    else $error("PLL off does not follow control and power-down");
  AST_PLL_KEEP: assert property (@(posedge core_clk) disable iff (!arst_n)
    !pll_r[`PVC_BIT_PLL_OFF] |-> !ctrl.pll_off)
    else $error("PLL turned off with control bit clear");
  AST_PLL_AWAKE: assert property (@(posedge core_clk) disable iff (!arst_n)
    !power_ctrl[`PVC_BIT_ENERGY_DETECT_EN] |-> !ctrl.pll_off)
    else $error("PLL turned off outside energy-detect power-down");
  AST_PLL_WR: assert property (@(posedge core_clk) disable iff (!arst_n)
    pll_write_seq |=> pll_r == $past(req.wdata))
    else $error("PLL control register missed write");
  AST_SLOW_WR: assert property (@(posedge core_clk) disable iff (!arst_n)
    afe_write_seq |=> ctrl.slow_osc_select == $past(req.wdata[`PVC_BIT_SLOW_OSC]))
    else $error("Slow oscillator select missed write");
  AST_AFE_WR: assert property (@(posedge core_clk) disable iff (!arst_n)
    afe_write_seq |=> afe_r == $past(req.wdata))
    else $error("Analog control register missed write");
  AST_SLOW_PD: assert property (@(posedge core_clk) disable iff (!arst_n)
    ctrl.slow_osc_select |-> ctrl.analog_power_down)
    else $error("Analog not powered down in slow oscillator mode");

  // A clearing read and an event in one cycle leave a count of one
  AST_CNT_INC: assert property (@(posedge core_clk) disable iff (!arst_n)
    symbol_error_frame && !req.rd && cnt_r < 16'hffff |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("Symbol error count did not advance");
  AST_CNT_CLR: assert property (@(posedge core_clk) disable iff (!arst_n)
    count_read_seq |=> rdata == $past(cnt_r) && cnt_r <= 16'h0001)
    else $error("Read did not return and clear count");
  AST_CNT_EVT_RD: assert property (@(posedge core_clk) disable iff (!arst_n)
    count_read_seq ##0 symbol_error_frame |=> cnt_r == 16'h0001)
    else $error("Event lost in clearing read cycle");
  AST_CNT_RO: assert property (@(posedge core_clk) disable iff (!arst_n)
    count_write_seq ##0 !symbol_error_frame |=> cnt_r == $past(cnt_r))
    else $error("Write changed read-only count");
  AST_CNT_SAT: assert property (@(posedge core_clk) disable iff (!arst_n)
    cnt_r == 16'hffff && !req.rd |=> cnt_r == 16'hffff)
    else $error("Counter wrapped");
  AST_CNT_SAT_RD: assert property (@(posedge core_clk) disable iff (!arst_n)
    count_read_seq ##0 cnt_r == 16'hffff |=> rdata == 16'hffff)
    else $error("Saturated count not returned by read");

  AST_RSVD_RO: assert property (@(posedge core_clk) disable iff (!arst_n)
    !ovr_r[`PVC_BIT_RSVD_RO])
    else $error("Read-only reserved bit set");
  AST_BCAST_OVR: assert property (@(posedge core_clk) disable iff (!arst_n)
    ovr_r[`PVC_BIT_BCAST_OVR] |-> ctrl.broadcast_address_disable)
    else $error("Override did not disable broadcast");
  AST_BCAST_WR: assert property (@(posedge core_clk) disable iff (!arst_n)
    strap_write_seq |=> ovr_r[`PVC_BIT_BCAST_OVR] == $past(req.wdata[`PVC_BIT_BCAST_OVR]))
    else $error("Broadcast override missed write");
  AST_BCAST_STRAP: assert property (@(posedge core_clk) disable iff (!arst_n)
    strap_r == PVC_STRAP_WAIT |=> bcast_strap_r == $past(bsync2_r))
    else $error("Broadcast strap not sampled after reset");
  AST_BCAST_HOLD: assert property (@(posedge core_clk) disable iff (!arst_n)
    strap_r == PVC_STRAP_DONE |=> $stable(bcast_strap_r))
    else $error("Sampled broadcast strap changed after capture");
  AST_BCAST_ADDR: assert property (@(posedge core_clk) disable iff (!arst_n)
    ctrl.broadcast_address_disable && mgmt_phy_addr == 5'h00 |-> phy_selected == (phy_addr == 5'h00))
    else $error("Address 0 treated as broadcast while disabled");
  AST_BCAST_ON: assert property (@(posedge core_clk) disable iff (!arst_n)
    !ctrl.broadcast_address_disable && mgmt_phy_addr == 5'h00 |-> phy_selected)
    else $error("Address 0 broadcast not answered");
  AST_OWN_ADDR: assert property (@(posedge core_clk) disable iff (!arst_n)
    mgmt_phy_addr == phy_addr |-> phy_selected)
    else $error("Own address not answered");
  AST_WAKE: assert property (@(posedge core_clk) disable iff (!arst_n)
    strap_r == PVC_STRAP_WAIT |=> ctrl.wake_event_output_enable == $past(wsync2_r))
    else $error("Wake enable not loaded from strap");
  AST_WAKE_WR: assert property (@(posedge core_clk) disable iff (!arst_n)
    strap_write_seq |=> ctrl.wake_event_output_enable == $past(req.wdata[`PVC_BIT_WAKE_EN]))
    else $error("Wake enable missed write");
endmodule : pvc_regs

//--- pkg/pvc_defs.svh
// Offsets, field positions, reset values for the vendor control registers.
// Assumes a 5-bit management register address and 16-bit register data.
`ifndef PVC_DEFS_SVH
`define PVC_DEFS_SVH
`define PVC_OFS_PLL_CTRL 5'h10
`define PVC_OFS_AFE_CTRL 5'h11
`define PVC_OFS_SYMERR 5'h15
`define PVC_OFS_STRAP_OVR 5'h16
`define PVC_OFS_POWER_CTRL 5'h18
`define PVC_BIT_PLL_OFF 4
`define PVC_BIT_SLOW_OSC 5
`define PVC_BIT_WAKE_EN 15
`define PVC_BIT_BCAST_OVR 9
`define PVC_BIT_RSVD_RO 10
`define PVC_BIT_ENERGY_DETECT_EN 11
`define PVC_RST_PLL_CTRL 16'h0000
`define PVC_RST_AFE_CTRL 16'h0000
`define PVC_RST_SYMERR 16'h0000
`define PVC_RST_STRAP_OVR 16'h0000
`define PVC_MASK_STRAP_RW 16'hfbff
`endif

//--- pkg/pvc_pkg.sv
// Types shared by the vendor control register bank.
// Assumes the register access port of the management interface.
package pvc_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } pvc_req_s;
  typedef struct packed {
    logic pll_off;
    logic analog_power_down;
    logic slow_osc_select;
    logic wake_event_output_enable;
    logic broadcast_address_disable;
  } pvc_ctrl_s;
  typedef enum logic [1:0] {
    PVC_STRAP_WAIT = 2'b00,
    PVC_STRAP_DONE = 2'b01
  } pvc_strap_e;
endpackage : pvc_pkg

//--- tb/pvc_mgmt_model.sv
// Management controller model: issues single-cycle register requests.
// Assumes the bench calls its tasks from the core_clk domain.
module pvc_mgmt_model
  import pvc_pkg::*;
(
  input wire logic core_clk,
  output pvc_req_s req,
  output logic [4:0] mgmt_phy_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    req = '0;
    mgmt_phy_addr = 5'h00;
  end
  // Released lines show inverted values so stale data never matches
  task automatic issue(input logic wr, input logic rd, input logic [4:0] addr, input logic [15:0] wdata);
    @(posedge core_clk);
    req <= '{wr: wr, rd: rd, addr: addr, wdata: wdata};
    @(posedge core_clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
  endtask : issue
  // Address 0 used both as broadcast and, while broadcast is off, as a plain address
  task automatic select(input logic [4:0] a);
    @(posedge core_clk);
    mgmt_phy_addr <= a;
  endtask : select
endmodule : pvc_mgmt_model

//--- tb/pvc_regs_tb.sv
// Self-checking bench for the vendor control registers against an integer model.
// Assumes reads answer one cycle after the request edge and writes act next cycle.
`include "pvc_defs.svh"
module pvc_regs_tb
  import pvc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 0, arst_n = 0, sym = 0, wstrap = 1, bstrap = 0, phy_sel;
  logic [15:0] pwr = 16'h0000, rdata, r10 = 16'h0000, r11 = 16'h0000, r16 = 16'h0000;
  logic [4:0] paddr = 5'h05, maddr;
  logic [31:0] seed = 32'h568fda66;
  pvc_req_s req;
  pvc_ctrl_s ctrl;
  int mismatches = 0, total_checks = 0, cnt = 0;
  logic [4:0] reg_list [5] = '{5'h10, 5'h11, 5'h15, 5'h16, 5'h1f};
  logic [15:0] afe_list [4] = '{16'h0020, 16'hffdf, 16'hffff, 16'h0000};
  logic [15:0] ovr_list [3] = '{16'hffff, 16'h0200, 16'h0000};
  pvc_regs dut_u (.core_clk(core_clk), .arst_n(arst_n), .req(req), .rdata(rdata), .power_ctrl(pwr),
    .symbol_error_frame(sym), .wake_event_strap(wstrap), .broadcast_strap(bstrap), .phy_addr(paddr),
    .mgmt_phy_addr(maddr), .phy_selected(phy_sel), .ctrl(ctrl));
  pvc_mgmt_model mm_u (.core_clk(core_clk), .req(req), .mgmt_phy_addr(maddr));
  always #2.5 core_clk = ~core_clk;
  // Saturating count; sym is kept low around clearing reads
  always @(posedge core_clk) if (sym && cnt < 65535) cnt <= cnt + 1;
  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction : rnd
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rd(input logic [4:0] a);
    logic [15:0] e;
    e = (a == 5'h10) ? r10 : (a == 5'h11) ? r11 : (a == 5'h15) ? 16'(cnt) : (a == 5'h16) ? r16 : 16'h0000;
    mm_u.issue(1'b0, 1'b1, a, rnd());
    #1 chk("rdata", e, rdata);
    if (a == 5'h15) cnt = 0;
  endtask : rd
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    mm_u.issue(1'b1, 1'b0, a, d);
    if (a == 5'h10) r10 = d;
    if (a == 5'h11) r11 = d;
    if (a == 5'h16) r16 = d & `PVC_MASK_STRAP_RW;
  endtask : wr
  task automatic cc();
    logic bd;
    bd = r16[9] | bstrap;
    chk("ctrl", {10'h000, r10[4] & pwr[11], r11[5], r11[5], r16[15], bd, (maddr == paddr) || (maddr == 5'h00 && !bd)},
      {10'h000, ctrl, phy_sel});
  endtask : cc
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    repeat (90000) @(posedge core_clk);
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    r16 = 16'h8000;
    foreach (reg_list[i]) rd(reg_list[i]);
    cc();
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(5'h10, i[1] ? rnd() | 16'h0010 : rnd() & 16'hffef);
      pwr <= {4'h0, i[0], 11'h000};
      @(posedge core_clk);
      #1 cc();
      rd(5'h10);
    end
    $display("test pll done");
    foreach (afe_list[i]) begin
      wr(5'h11, afe_list[i]);
      #1 cc();
      rd(5'h11);
    end
    $display("test oscillator done");
    foreach (ovr_list[i]) begin
      wr(5'h16, ovr_list[i]);
      for (int k = 0; k < 3; k++) begin
        mm_u.select(k == 0 ? 5'h00 : k == 1 ? 5'h05 : 5'h07);
        #1 cc();
      end
      rd(5'h16);
    end
    $display("test strap override done");
    wr(5'h15, rnd());
    wr(5'h1f, rnd());
    repeat (rnd() % 40 + 1) begin
      @(posedge core_clk) sym <= 1'b1;
      @(posedge core_clk) sym <= 1'b0;
    end
    @(posedge core_clk);
    rd(5'h15);
    rd(5'h15);
    @(posedge core_clk) sym <= 1'b1;
    repeat (65540) @(posedge core_clk);
    sym <= 1'b0;
    @(posedge core_clk);
    rd(5'h15);
    rd(5'h15);
    $display("test counter done");
    // Second reset with both straps flipped: wake low, broadcast disable high
    @(posedge core_clk) arst_n <= 1'b0;
    wstrap <= 1'b0;
    bstrap <= 1'b1;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    r10 = 16'h0000;
    r11 = 16'h0000;
    r16 = 16'h0000;
    cnt = 0;
    repeat (2) @(posedge core_clk);
    foreach (reg_list[i]) rd(reg_list[i]);
    mm_u.select(5'h00);
    #1 cc();
    mm_u.select(5'h05);
    #1 cc();
    $display("test strap reset done");
    finish_test();
  end
endmodule : pvc_regs_tb
